// File: src/ptbd_cfg.svh
`ifndef PTBD_CFG_SVH
`define PTBD_CFG_SVH

// ----------------------------------------------------------------
// Register map: indices, byte address is index times word bytes
// ----------------------------------------------------------------
`define PTBD_WORD_BYTES     8'h04
`define PTBD_IDX_CTL        8'h36
`define PTBD_IDX_STAT       8'h37
`define PTBD_IDX_IEN        8'h38
`define PTBD_IDX_ICLR       8'h39
`define PTBD_ADDR_W         8
`define PTBD_DATA_W         32
`define PTBD_CTL_RESET      8'h00
`define PTBD_IRQ_RESET      1'h0

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PTBD_BIT_BUZ_EN     7
`define PTBD_BUZ_RATE_HI    6
`define PTBD_BUZ_RATE_LO    5
`define PTBD_BIT_SRC        4
`define PTBD_BIT_TICK_EN    3
`define PTBD_TICK_RATE_HI   2
`define PTBD_TICK_RATE_LO   0
`define PTBD_BIT_IRQ_TICK   0

// ----------------------------------------------------------------
// Shared divider taps: bit k has a period of 2^(k+1) input clocks
// ----------------------------------------------------------------
`define PTBD_DIV_W          23
`define PTBD_TAP_W          5
`define PTBD_TAP_D23        5'h16
`define PTBD_TAP_D21        5'h14
`define PTBD_TAP_D16        5'h0f
`define PTBD_TAP_D14        5'h0d
`define PTBD_TAP_D13        5'h0c
`define PTBD_TAP_D12        5'h0b
`define PTBD_TAP_D11        5'h0a
`define PTBD_TAP_D10        5'h09
`define PTBD_TAP_D9         5'h08
`define PTBD_SLOW_MAX_CODE  3'h1

// ----------------------------------------------------------------
// AHB-Lite encodings
// ----------------------------------------------------------------
`define PTBD_HTRANS_NONSEQ  2'h2
`define PTBD_HSIZE_WORD     3'h2
`define PTBD_HRESP_OKAY     1'h0

`endif

// File: src/ptbd_pkg.sv
`include "ptbd_cfg.svh"

package ptbd_pkg;

	typedef struct packed {
		logic                      ff1;
		logic                      ff2;
		logic                      ff3;
		logic                      level;
	} ptbd_sync_state_type;

	typedef struct packed {
		logic                      status;
		logic                      enable;
		logic                      irq;
	} ptbd_irq_state_type;

	typedef struct packed {
		logic [7:0]                control;
		logic                      hready;
		logic                      hresp;
		logic [`PTBD_DATA_W-1:0]   hrdata;
		logic                      wr_pend;
		logic [`PTBD_ADDR_W-1:0]   wr_addr;
		logic                      tick_prev;
		logic                      tick_pulse;
		logic                      buzzer_pin;
	} ptbd_top_state_type;

endpackage

// File: src/ptbd_sync.sv
`timescale 1ns/10ps
`include "ptbd_cfg.svh"

// ----------------------------------------------------------------
// Three-stage input filter: level moves once ff2 and ff3 agree
// ----------------------------------------------------------------
module ptbd_sync (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic async_in,
	output logic      level_out
);

	ptbd_pkg::ptbd_sync_state_type state;
	ptbd_pkg::ptbd_sync_state_type next_state;

	always_comb begin
		next_state       = state;
		next_state.ff1   = async_in;
		next_state.ff2   = state.ff1;
		next_state.ff3   = state.ff2;
		if (state.ff2 == state.ff3) begin
			next_state.level = state.ff3;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign level_out = state.level;

endmodule

// File: src/ptbd_irq.sv
`timescale 1ns/10ps
`include "ptbd_cfg.svh"

// ----------------------------------------------------------------
// Sticky status, enable and level interrupt
// ----------------------------------------------------------------
module ptbd_irq (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic event_in,
	input  wire logic enable_wr_in,
	input  wire logic enable_data_in,
	input  wire logic clear_wr_in,
	input  wire logic clear_data_in,
	output logic      status_out,
	output logic      enable_out,
	output logic      irq_out
);

	ptbd_pkg::ptbd_irq_state_type state;
	ptbd_pkg::ptbd_irq_state_type next_state;

	always_comb begin
		next_state = state;
		if (enable_wr_in) begin
			next_state.enable = enable_data_in;
		end
		// Set wins over a clear in the same cycle
		if (event_in) begin
			next_state.status = 1'h1;
		end else if (clear_wr_in && clear_data_in) begin
			next_state.status = 1'h0;
		end
		next_state.irq = next_state.status & next_state.enable;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign status_out = state.status;
	assign enable_out = state.enable;
	assign irq_out    = state.irq;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	a_irq_set_wins: assert property (event_in |=> status_out)
		else $error("event lost against clear");
	a_irq_level: assert property (irq_out == (status_out & enable_out))
		else $error("interrupt level does not match status and enable");

endmodule

// File: src/ptbd_top.sv
`timescale 1ns/10ps
`include "ptbd_cfg.svh"

// Notes on behaviour
// (R01) In fast modes the tick tap follows rate codes 0 to 7 as listed.
// (R02) In slow modes only tick codes 0 and 1 are valid, others tick never.
// (R03) Software changes the tick rate only with the tick disabled.
// (R04) An enabled tick pulses on every falling edge of its tap.
// (R05) Enabling the tick never clears the shared divider.
// (R06) An enabled buzzer pin is an active low square wave of the tap.
// (R07) Buzzer codes 0 to 3 pick the taps divided by 2^13 down to 2^10.
// (R08) Each enable bit turns its function on at 1, off at 0, readable.
// (R09) Software changes the buzzer rate only with the buzzer disabled.
// (R10) Control fields sit at their fixed bits and reset to zero.
// (R11) A tick is a one-cycle pulse and an idle buzzer pin rests high.
module ptbd_top (
	input  wire logic                    ref_clk_in,
	input  wire logic                    rst_in,
	input  wire logic                    hsel_in,
	input  wire logic [31:0]             haddr_in,
	input  wire logic [1:0]              htrans_in,
	input  wire logic                    hwrite_in,
	input  wire logic [2:0]              hsize_in,
	input  wire logic [31:0]             hwdata_in,
	input  wire logic                    hready_in,
	input  wire logic [`PTBD_DIV_W-1:0]  divider_in,
	input  wire logic                    slow_mode_in,
	output logic                         hreadyout_out,
	output logic                         hresp_out,
	output logic [31:0]                  hrdata_out,
	output logic                         tick_interrupt_out,
	output logic                         irq_out,
	output logic                         buzzer_output_pin_out,
	output logic                         prescaler_source_select_out
);

	// ----------------------------------------------------------------
	// Addresses
	// ----------------------------------------------------------------
	localparam logic [`PTBD_ADDR_W-1:0] ADDR_CTL  =
		`PTBD_ADDR_W'(`PTBD_IDX_CTL * `PTBD_WORD_BYTES);
	localparam logic [`PTBD_ADDR_W-1:0] ADDR_STAT =
		`PTBD_ADDR_W'(`PTBD_IDX_STAT * `PTBD_WORD_BYTES);
	localparam logic [`PTBD_ADDR_W-1:0] ADDR_IEN  =
		`PTBD_ADDR_W'(`PTBD_IDX_IEN * `PTBD_WORD_BYTES);
	localparam logic [`PTBD_ADDR_W-1:0] ADDR_ICLR =
		`PTBD_ADDR_W'(`PTBD_IDX_ICLR * `PTBD_WORD_BYTES);

	ptbd_pkg::ptbd_top_state_type state;
	ptbd_pkg::ptbd_top_state_type next_state;

	logic                        tick_en;
	logic                        buz_en;
	logic [2:0]                  tick_rate;
	logic [1:0]                  buz_rate;
	logic [`PTBD_TAP_W-1:0]      tick_idx;
	logic [`PTBD_TAP_W-1:0]      buz_idx;
	logic                        tick_tap;
	logic                        buz_tap;
	logic                        tick_level;
	logic                        buz_level;
	logic                        tick_fall;
	logic                        tick_code_ok;
	logic                        addr_phase;
	logic                        rd_take;
	logic [`PTBD_ADDR_W-1:0]     addr_lo;
	logic [31:0]                 rd_value;
	logic                        ien_wr;
	logic                        iclr_wr;
	logic                        irq_status;
	logic                        irq_enable;
	logic                        irq_level;

	// ----------------------------------------------------------------
	// Tap tables
	// ----------------------------------------------------------------
	function automatic logic [`PTBD_TAP_W-1:0] tick_tap_of(
		input logic [2:0] code
	);
		logic [`PTBD_TAP_W-1:0] idx;
		idx = `PTBD_TAP_D23;
		case (code)
			3'h0: idx = `PTBD_TAP_D23;
			3'h1: idx = `PTBD_TAP_D21;
			3'h2: idx = `PTBD_TAP_D16;
			3'h3: idx = `PTBD_TAP_D14;
			3'h4: idx = `PTBD_TAP_D13;
			3'h5: idx = `PTBD_TAP_D12;
			3'h6: idx = `PTBD_TAP_D11;
			default: idx = `PTBD_TAP_D9;
		endcase
		return idx;
	endfunction

	function automatic logic [`PTBD_TAP_W-1:0] buz_tap_of(
		input logic [1:0] code
	);
		logic [`PTBD_TAP_W-1:0] idx;
		idx = `PTBD_TAP_D13;
		case (code)
			2'h0: idx = `PTBD_TAP_D13;
			2'h1: idx = `PTBD_TAP_D12;
			2'h2: idx = `PTBD_TAP_D11;
			default: idx = `PTBD_TAP_D10;
		endcase
		return idx;
	endfunction

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	assign tick_en   = state.control[`PTBD_BIT_TICK_EN];
	assign buz_en    = state.control[`PTBD_BIT_BUZ_EN];
	assign tick_rate = state.control[`PTBD_TICK_RATE_HI:`PTBD_TICK_RATE_LO];
	assign buz_rate  = state.control[`PTBD_BUZ_RATE_HI:`PTBD_BUZ_RATE_LO];

	// ----------------------------------------------------------------
	// Tap selection
	// ----------------------------------------------------------------
	// (R01) fast mode tick taps
	// Source select moves the divider input outside; taps keep their index
	assign tick_idx = tick_tap_of(tick_rate);
	// (R07) buzzer tap per code
	assign buz_idx  = buz_tap_of(buz_rate);
	assign tick_tap = divider_in[tick_idx];
	assign buz_tap  = divider_in[buz_idx];

	ptbd_sync u_tick_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (tick_tap),
		.level_out  (tick_level)
	);

	ptbd_sync u_buz_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (buz_tap),
		.level_out  (buz_level)
	);

	// (R02) slow mode accepts only the two lowest codes
	assign tick_code_ok = !slow_mode_in || (tick_rate <= `PTBD_SLOW_MAX_CODE);
	// (R04) falling edge of the selected tap
	assign tick_fall    = state.tick_prev && !tick_level;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign addr_lo    = haddr_in[`PTBD_ADDR_W-1:0];
	assign addr_phase = hsel_in && hready_in && htrans_in[1] &&
		(hsize_in == `PTBD_HSIZE_WORD);
	assign rd_take    = addr_phase && !hwrite_in;
	assign ien_wr     = state.wr_pend && (state.wr_addr == ADDR_IEN);
	assign iclr_wr    = state.wr_pend && (state.wr_addr == ADDR_ICLR);

	always_comb begin
		rd_value = 32'h0000_0000;
		case (addr_lo)
			ADDR_CTL:  rd_value = {24'h00_0000, state.control};
			ADDR_STAT: rd_value = {31'h0000_0000, irq_status};
			ADDR_IEN:  rd_value = {31'h0000_0000, irq_enable};
			default:   rd_value = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state         = state;
		next_state.hready  = 1'h1;
		next_state.hresp   = `PTBD_HRESP_OKAY;
		next_state.wr_pend = addr_phase && hwrite_in;
		next_state.wr_addr = addr_lo;
		if (rd_take) begin
			next_state.hrdata = rd_value;
		end
		// (R10) control register write in the data phase
		if (state.wr_pend && (state.wr_addr == ADDR_CTL)) begin
			next_state.control = hwdata_in[7:0];
		end
		// (R05) tap history runs free, enabling never resets it
		next_state.tick_prev  = tick_level;
		// (R11) single-cycle tick request
		next_state.tick_pulse = tick_en && tick_code_ok && tick_fall;
		// (R06) active low square wave, idle high
		next_state.buzzer_pin = buz_en ? !buz_level : 1'h1;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state            <= '0;
			state.control    <= `PTBD_CTL_RESET;
			state.hready     <= 1'h1;
			state.tick_prev  <= 1'h0;
			state.buzzer_pin <= 1'h1;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt registers
	// ----------------------------------------------------------------
	ptbd_irq u_irq (
		.ref_clk_in     (ref_clk_in),
		.rst_in         (rst_in),
		.event_in       (state.tick_pulse),
		.enable_wr_in   (ien_wr),
		.enable_data_in (hwdata_in[`PTBD_BIT_IRQ_TICK]),
		.clear_wr_in    (iclr_wr),
		.clear_data_in  (hwdata_in[`PTBD_BIT_IRQ_TICK]),
		.status_out     (irq_status),
		.enable_out     (irq_enable),
		.irq_out        (irq_level)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hreadyout_out               = state.hready;
	assign hresp_out                   = state.hresp;
	assign hrdata_out                  = state.hrdata;
	assign tick_interrupt_out          = state.tick_pulse;
	assign irq_out                     = irq_level;
	assign buzzer_output_pin_out       = state.buzzer_pin;
	assign prescaler_source_select_out = state.control[`PTBD_BIT_SRC];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	localparam int BUZ_EN_BIT  = `PTBD_BIT_BUZ_EN;
	localparam int TICK_EN_BIT = `PTBD_BIT_TICK_EN;

	sequence s_ctl_write;
		state.wr_pend && (state.wr_addr == ADDR_CTL);
	endsequence

	sequence s_ctl_read;
		rd_take && (addr_lo == ADDR_CTL);
	endsequence

	sequence s_tap_fall;
		tick_en && tick_code_ok && state.tick_prev ##0 !tick_level;
	endsequence

	property p_ctl_write;
		s_ctl_write |=> state.control == $past(hwdata_in[7:0]);
	endproperty

	property p_ctl_read;
		s_ctl_read |=> hrdata_out == {24'h00_0000, $past(state.control)};
	endproperty

	property p_tick_cause;
		tick_interrupt_out |-> $past(tick_en) && $past(tick_fall);
	endproperty

	a_ctl_reset_zero: assert property ($past(rst_in) |-> //(R10)
		state.control == `PTBD_CTL_RESET)
		else $error("control not zero after reset");
	a_ctl_write_load: assert property (p_ctl_write) //(R10)
		else $error("control write not stored");
	a_ctl_read_back: assert property (p_ctl_read) //(R08)
		else $error("control read data wrong");
	a_tick_on_fall: assert property (s_tap_fall |=> tick_interrupt_out) //(R04)
		else $error("falling tap edge gave no tick");
	a_tick_cause: assert property (p_tick_cause) //(R08)
		else $error("tick without enable or edge");
	a_tick_one_cycle: assert property (tick_interrupt_out |=> //(R11)
		!tick_interrupt_out)
		else $error("tick request longer than one cycle");
	a_tick_slow_code: assert property (tick_interrupt_out |-> //(R02)
		!($past(slow_mode_in) && ($past(tick_rate) > `PTBD_SLOW_MAX_CODE)))
		else $error("tick on an undefined slow mode code");
	a_tick_tap_slow: assert property ((tick_rate == 3'h0) |-> //(R01)
		tick_tap == divider_in[`PTBD_TAP_D23])
		else $error("tick code zero picks the wrong tap");
	a_buz_tap_fast: assert property ((buz_rate == 2'h3) |-> //(R07)
		buz_tap == divider_in[`PTBD_TAP_D10])
		else $error("buzzer code three picks the wrong tap");
	a_buz_idle_high: assert property (!$past(state.control[BUZ_EN_BIT]) //(R11)
		|-> buzzer_output_pin_out)
		else $error("idle buzzer pin not high");
	a_buz_wave: assert property ($past(state.control[BUZ_EN_BIT]) |-> //(R06)
		buzzer_output_pin_out == !$past(buz_level))
		else $error("buzzer pin does not follow tap");
	a_tick_no_clear: assert property ($rose(state.control[TICK_EN_BIT]) //(R05)
		|-> state.tick_prev == $past(tick_level))
		else $error("enable disturbed tap history");

endmodule

// File: testbench/ptbd_far_side.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Far side: free divider, interrupt taker and buzzer meter
// ----------------------------------------------------------------
module ptbd_far_side (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic [4:0]  step_in,
	input  wire logic        tick_in,
	input  wire logic        buzzer_in,
	output logic      [22:0] divider_out,
	output logic      [15:0] ticks_out,
	output logic      [15:0] widest_out,
	output logic      [15:0] low_out,
	output logic      [15:0] falls_out
);
	logic [15:0] run;
	logic        buz_prev;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			divider_out <= 23'h000000;
			ticks_out   <= 16'h0000;
			widest_out  <= 16'h0000;
			low_out     <= 16'h0000;
			falls_out   <= 16'h0000;
			run         <= 16'h0000;
			buz_prev    <= 1'b1;
		end else begin
			// Step scales the input clock to keep runs short
			divider_out <= divider_out + (23'h000001 << step_in);
			buz_prev    <= buzzer_in;
			if (tick_in) begin
				run <= run + 16'h0001;
				if (run == 16'h0000) begin
					ticks_out <= ticks_out + 16'h0001;
				end
				if (run + 16'h0001 > widest_out) begin
					widest_out <= run + 16'h0001;
				end
			end else begin
				run <= 16'h0000;
			end
			if (!buzzer_in) begin
				low_out <= low_out + 16'h0001;
			end
			if (buz_prev && !buzzer_in) begin
				falls_out <= falls_out + 16'h0001;
			end
		end
	end
endmodule

// File: testbench/ptbd_bench.sv
`timescale 1ns/10ps
`include "ptbd_cfg.svh"

module ptbd_bench;
	localparam logic [7:0] CTL  = 8'(`PTBD_IDX_CTL * `PTBD_WORD_BYTES);
	localparam logic [7:0] STAT = 8'(`PTBD_IDX_STAT * `PTBD_WORD_BYTES);
	localparam logic [7:0] IEN  = 8'(`PTBD_IDX_IEN * `PTBD_WORD_BYTES);
	localparam logic [7:0] ICLR = 8'(`PTBD_IDX_ICLR * `PTBD_WORD_BYTES);
	localparam int         TTAP [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
	localparam int         BTAP [4] = '{12, 11, 10, 9};

	logic        clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic        slow;
	logic [4:0]  step;
	logic [22:0] divider;
	logic        tick;
	logic        irq;
	logic        buz;
	logic        src;
	logic [15:0] ticks;
	logic [15:0] widest;
	logic [15:0] low;
	logic [15:0] falls;
	int          fail_count;
	int          checks_done;

	ptbd_top dut (
		.ref_clk_in                  (clk),
		.rst_in                      (rst),
		.hsel_in                     (hsel),
		.haddr_in                    (haddr),
		.htrans_in                   (htrans),
		.hwrite_in                   (hwrite),
		.hsize_in                    (hsize),
		.hwdata_in                   (hwdata),
		.hready_in                   (hready),
		.divider_in                  (divider),
		.slow_mode_in                (slow),
		.hreadyout_out               (hready),
		.hresp_out                   (hresp),
		.hrdata_out                  (hrdata),
		.tick_interrupt_out          (tick),
		.irq_out                     (irq),
		.buzzer_output_pin_out       (buz),
		.prescaler_source_select_out (src)
	);

	ptbd_far_side far (
		.ref_clk_in  (clk),
		.rst_in      (rst),
		.step_in     (step),
		.tick_in     (tick),
		.buzzer_in   (buz),
		.divider_out (divider),
		.ticks_out   (ticks),
		.widest_out  (widest),
		.low_out     (low),
		.falls_out   (falls)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s: expected 0x%h, seen 0x%h", what, exp, seen);
		end
	endtask

	task final_report;
		if (fail_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= `PTBD_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize  <= `PTBD_HSIZE_WORD;
		@(posedge clk);
		while (hready !== 1'b1 && n < 64) begin
			@(posedge clk);
			n++;
		end
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1 && n < 128) begin
			@(posedge clk);
			n++;
		end
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a,
			input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h00000000, x);
		check(what, x, exp);
		check("read response", {31'h0, hresp}, 32'h0);
	endtask

	// Settle, then measure one 2048-cycle window at the far side
	task automatic window(output logic [15:0] t, output logic [15:0] l,
			output logic [15:0] f);
		logic [15:0] t0;
		logic [15:0] l0;
		logic [15:0] f0;
		repeat (600) @(posedge clk);
		t0 = ticks;
		l0 = low;
		f0 = falls;
		repeat (2048) @(posedge clk);
		t = ticks - t0;
		l = low - l0;
		f = falls - f0;
	endtask

	task automatic tick_run(input int c, input logic [15:0] exp);
		logic [15:0] t;
		logic [15:0] l;
		logic [15:0] f;
		step <= 5'(TTAP[c] - 8);
		wr(CTL, {28'h0000000, 1'b1, 3'(c)});
		window(t, l, f);
		check("tick count", {16'h0000, t}, {16'h0000, exp});
		wr(CTL, {29'h00000000, 3'(c)});
	endtask

	// ----------------------------------------------------------------
	// Clock, reset and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		final_report;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] t;
		logic [15:0] l;
		logic [15:0] f;
		int          n;
		fail_count  = 0;
		checks_done = 0;
		rst    <= 1'b1;
		hsel   <= 1'b0;
		haddr  <= 32'h00000000;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize  <= `PTBD_HSIZE_WORD;
		hwdata <= 32'h00000000;
		slow   <= 1'b0;
		step   <= 5'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk("control reset", CTL, 32'h00000000);
		check("idle pin", {31'h0, buz}, 32'h1);
		wr(CTL, 32'h000000ff);
		rdchk("control all ones", CTL, 32'h000000ff);
		check("source select", {31'h0, src}, 32'h1);
		wr(CTL, 32'h00000077);
		rdchk("control disable", CTL, 32'h00000077);
		wr(CTL, 32'h00000000);
		wr(8'h00, 32'h000000ff);
		rdchk("unmapped read", 8'h00, 32'h00000000);
		rdchk("control kept", CTL, 32'h00000000);
		for (int c = 0; c < 8; c++) begin
			tick_run(c, 16'h0004);
		end
		check("tick width", {16'h0000, widest}, 32'h1);
		slow <= 1'b1;
		tick_run(0, 16'h0004);
		tick_run(1, 16'h0004);
		tick_run(5, 16'h0000);
		slow <= 1'b0;
		step <= 5'h00;
		n = 0;
		while (divider[8:0] !== 9'h1e0 && n < 1024) begin
			@(posedge clk);
			n++;
		end
		t = ticks;
		wr(CTL, 32'h0000000f);
		repeat (64) @(posedge clk);
		check("first tick early", {16'h0000, ticks - t}, 32'h1);
		wr(CTL, 32'h00000007);
		rdchk("status set", STAT, 32'h00000001);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(IEN, 32'h00000001);
		repeat (2) @(posedge clk);
		check("irq raised", {31'h0, irq}, 32'h1);
		rdchk("enable read", IEN, 32'h00000001);
		wr(ICLR, 32'h00000001);
		rdchk("status clear", STAT, 32'h00000000);
		check("irq cleared", {31'h0, irq}, 32'h0);
		rdchk("clear reads 0", ICLR, 32'h00000000);
		window(t, l, f);
		check("pin disabled", {16'h0000, l}, 32'h0);
		for (int b = 0; b < 4; b++) begin
			step <= 5'(BTAP[b] - 8);
			wr(CTL, {24'h000000, 1'b0, 2'(b), 5'h00});
			wr(CTL, {24'h000000, 1'b1, 2'(b), 5'h00});
			window(t, l, f);
			check("buzzer edges", {16'h0000, f}, 32'h4);
			check("buzzer low", {16'h0000, l}, 32'h400);
			wr(CTL, {24'h000000, 1'b0, 2'(b), 5'h00});
		end
		repeat (8) @(posedge clk);
		check("pin rests high", {31'h0, buz}, 32'h1);
		final_report;
	end
endmodule
